/* File: logic/cfgatr_bank.sv */
// Configuration register bank with per-bit access attributes
`timescale 1ns/1ps
`default_nettype none
`include "cfgatr_defines.svh"

// Contract
// - Read-only bits ignore all writes
// - Read/write bits store and return data
// - Writing one clears bit; zero keeps
// - Write-once bits accept only first write
// - Lockable bits read-only once lock set
// - Reserved locations return unspecified value
// - Full reset loads every default value
// - Some defaults come from strap inputs
// - Straps captured during reset assertion; code samples them at the first edge after release
// - Byte/word/dword access; address reg dword only
// - Little-endian byte ordering of fields
module cfgatr_bank #(
  parameter int                     NUM_REGS   = `CFGATR_NUM_REGS,
  parameter logic [NUM_REGS*32-1:0] RESET_VAL  = '0,
  parameter logic [NUM_REGS*32-1:0] STRAP_MASK = '0,
  parameter logic [NUM_REGS*96-1:0] ATTR_MAP   = '0,
  parameter logic [NUM_REGS*32-1:0] LOCK_SEL   = '0
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire cfgatr_pkg::cfgatr_req_t req,
  input  wire logic [NUM_REGS*32-1:0]  strapIn,
  input  wire logic [NUM_REGS*32-1:0]  setIn,
  output logic [31:0]                  rdData,
  output logic                         rdValid,
  output logic [NUM_REGS*32-1:0]       regOut
);

  // ----------------------------------------------------------------
  // Storage and shared state
  // ----------------------------------------------------------------
  logic [NUM_REGS*32-1:0] store_q;
  logic [NUM_REGS*32-1:0] once_q;
  logic                   strapDone_q;
  logic                   lockHit;

  // ----------------------------------------------------------------
  // Strap window
  // ----------------------------------------------------------------
  // Open from reset until the first edge after release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strapDone_q <= 1'b0;
    end else begin
      strapDone_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write lane decode
  // ----------------------------------------------------------------
  logic [3:0]  laneEn;
  logic [4:0]  wrShift;
  logic [31:0] wdAligned;
  logic        addrOk;
  logic        wrOk;

  // Byte lanes touched by the access
  always_comb begin
    laneEn = 4'h0;
    unique case (req.size)
      cfgatr_pkg::SIZE_BYTE: begin
        laneEn = 4'h1 << req.byteOfs;
      end
      cfgatr_pkg::SIZE_WORD: begin
        laneEn = req.byteOfs[1] ? 4'hC : 4'h3;
      end
      cfgatr_pkg::SIZE_DWORD: begin
        laneEn = 4'hF;
      end
      default: begin
        laneEn = 4'h0;
      end
    endcase
  end

  // Move low-aligned data up to the lanes it writes
  always_comb begin
    wrShift = 5'h00;
    unique case (req.size)
      cfgatr_pkg::SIZE_BYTE: begin
        wrShift = {req.byteOfs, 3'h0};
      end
      cfgatr_pkg::SIZE_WORD: begin
        wrShift = {req.byteOfs[1], 4'h0};
      end
      cfgatr_pkg::SIZE_DWORD: begin
        wrShift = 5'h00;
      end
      default: begin
        wrShift = 5'h00;
      end
    endcase
    wdAligned = req.wdata << wrShift;
  end

  // Narrow writes to the address register are dropped
  assign addrOk = (req.idx != `CFGATR_ADDR_REG_IDX) ||
                  (req.size == cfgatr_pkg::SIZE_DWORD);
  assign wrOk   = req.wr && addrOk;

  // ----------------------------------------------------------------
  // Lock control
  // ----------------------------------------------------------------
  // Any set lock-control bit freezes every lockable bit
  assign lockHit = |(store_q & LOCK_SEL);

  // ----------------------------------------------------------------
  // Per-bit storage
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_REGS*32; g++) begin : gBit
      localparam int REG = g / 32;
      localparam int BIT = g % 32;
      localparam cfgatr_pkg::cfgatr_attr_t ATTR =
        cfgatr_pkg::cfgatr_attr_t'(ATTR_MAP[g*3 +: 3]);

      // Lane hit and data bit for this position
      logic hit;
      logic wbit;

      assign hit  = wrOk && (req.idx == REG[2:0]) && laneEn[BIT/8];
      assign wbit = wdAligned[BIT];

      // Stored value, by attribute
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          store_q[g] <= RESET_VAL[g];
        end else if (!strapDone_q && STRAP_MASK[g]) begin
          store_q[g] <= strapIn[g];
        end else begin
          unique case (ATTR)
            cfgatr_pkg::ATTR_RW: begin
              if (hit) begin
                store_q[g] <= wbit;
              end
            end
            cfgatr_pkg::ATTR_WC: begin
              if (setIn[g]) begin
                store_q[g] <= 1'b1;
              end else if (hit && wbit) begin
                store_q[g] <= 1'b0;
              end
            end
            cfgatr_pkg::ATTR_WO: begin
              if (hit && !once_q[g]) begin
                store_q[g] <= wbit;
              end
            end
            cfgatr_pkg::ATTR_LOCK: begin
              if (hit && !lockHit) begin
                store_q[g] <= wbit;
              end
            end
            default: begin
              store_q[g] <= store_q[g];
            end
          endcase
        end
      end

      // Write-once tracking, cleared only by reset
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          once_q[g] <= 1'b0;
        end else if (ATTR == cfgatr_pkg::ATTR_WO && hit) begin
          once_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdWord;
  logic [4:0]  rdShift;
  logic        rsvdLoc;

  always_comb begin
    rdWord  = store_q[req.idx*32 +: 32];
    rdShift = {req.byteOfs, 3'h0};
    rsvdLoc = (ATTR_MAP[req.idx*96 +: 3] ==
               3'(cfgatr_pkg::ATTR_RSVD));
  end

  // Read strobe answered one cycle later
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= req.rd;
    end
  end

  // Addressed byte lands in the low lane
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 32'h0000_0000;
    end else if (req.rd && rsvdLoc) begin
      rdData <= `CFGATR_RSVD_FILL;
    end else if (req.rd) begin
      rdData <= rdWord >> rdShift;
    end
  end

  // ----------------------------------------------------------------
  // Register image
  // ----------------------------------------------------------------
  assign regOut = store_q;

endmodule
`default_nettype wire

/* File: logic/cfgatr_defines.svh */
// Constants for the configuration register attribute bank
`ifndef CFGATR_DEFINES_SVH
`define CFGATR_DEFINES_SVH

`define CFGATR_NUM_REGS     8
`define CFGATR_IDX_W        3
`define CFGATR_ADDR_REG_IDX 3'h0
`define CFGATR_RSVD_FILL    32'h0000_0000

`endif

/* File: logic/cfgatr_pkg.sv */
// Types for the configuration register attribute bank
package cfgatr_pkg;

  typedef enum logic [2:0] {
    ATTR_RO     = 3'h0,
    ATTR_RW     = 3'h1,
    ATTR_WC     = 3'h2,
    ATTR_WO     = 3'h3,
    ATTR_LOCK   = 3'h4,
    ATTR_RSVD   = 3'h5
  } cfgatr_attr_t;

  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_WORD  = 2'h1,
    SIZE_DWORD = 2'h2
  } cfgatr_size_t;

  typedef struct packed {
    logic         wr;
    logic         rd;
    logic [2:0]   idx;
    logic [1:0]   byteOfs;
    cfgatr_size_t size;
    logic [31:0]  wdata;
  } cfgatr_req_t;

endpackage

/* File: test/cfgatr_bank_sva.sv */
// Assertions for the configuration register attribute bank
`timescale 1ns/1ps
`default_nettype none
module cfgatr_bank_sva #(
  parameter int NUM_REGS = 8
) (
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  input wire cfgatr_pkg::cfgatr_req_t req,
  input wire logic [NUM_REGS*32-1:0]  strapIn,
  input wire logic [NUM_REGS*32-1:0]  setIn,
  input wire logic [31:0]             rdData,
  input wire logic                    rdValid,
  input wire logic [NUM_REGS*32-1:0]  regOut
);
  // Bit map as set up by the bench: reg1 RW/RO/WC/WO bytes, reg2 bytes 1-3 lockable
  wire wr1 = req.wr && req.idx == 3'h1;
  wire dw  = req.size == cfgatr_pkg::SIZE_DWORD;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_locked_wr;
    regOut[64] ##1 (regOut[64] && req.wr && req.idx == 3'h2);
  endsequence
  a_rd_valid: assert property (req.rd |=> rdValid)
    else $error("read not answered");
  a_no_valid: assert property (!req.rd |=> !rdValid)
    else $error("answer without read");
  a_rd_lane: assert property (req.rd && req.idx == 3'h1 && req.byteOfs == 2'h1
    |=> rdData[7:0] == $past(regOut[47:40]))
    else $error("read lane wrong");
  a_ro_hold: assert property (wr1 |=> $stable(regOut[47:40]))
    else $error("read-only byte changed");
  a_rw_store: assert property (wr1 && dw
    |=> regOut[39:32] == $past(req.wdata[7:0]))
    else $error("rw byte not stored");
  a_wc_clear: assert property (wr1 && dw && req.wdata[16] && !setIn[48]
    |=> !regOut[48])
    else $error("clear bit not cleared");
  a_wc_set: assert property (setIn[48] |=> regOut[48])
    else $error("set event lost");
  a_addr_dword: assert property (req.wr && req.idx == 3'h0 && !dw
    |=> $stable(regOut[31:0]))
    else $error("narrow address write took");
  a_lock_hold: assert property (s_locked_wr |=> $stable(regOut[95:72]))
    else $error("locked bits changed");
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Testbench for the configuration register attribute bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam cfgatr_pkg::cfgatr_size_t BY = cfgatr_pkg::SIZE_BYTE;
  localparam cfgatr_pkg::cfgatr_size_t WD = cfgatr_pkg::SIZE_WORD;
  localparam cfgatr_pkg::cfgatr_size_t DW = cfgatr_pkg::SIZE_DWORD;
  logic                    ref_clk = 0;
  logic                    rstn = 0;
  cfgatr_pkg::cfgatr_req_t req = '0;
  logic [255:0]            strapIn = {152'h0, 8'hC3, 96'h0};
  logic [255:0]            setIn = '0;
  logic [255:0]            regOut;
  logic [31:0]             rdData;
  logic                    rdValid;
  int                      error_cnt = 0;
  int                      compares = 0;
  function automatic logic [767:0] amap();
    for (int b = 0; b < 256; b++) begin
      amap[b*3+:3] = b < 40 || b == 64 ? 3'h1 : b < 48 ? 3'h0 : b < 56 ? 3'h2
        : b < 64 ? 3'h3 : b > 71 && b < 96 ? 3'h4 : b > 223 ? 3'h5 : 3'h0;
    end
  endfunction
  cfgatr_bank #(.RESET_VAL({192'h0, 32'h00FF_5A00, 32'h0}),
    .STRAP_MASK({152'h0, 8'hFF, 96'h0}), .ATTR_MAP(amap()),
    .LOCK_SEL({191'h0, 1'h1, 64'h0})) dut (.ref_clk, .rstn, .req,
    .strapIn, .setIn, .rdData, .rdValid, .regOut);
  initial forever #10 ref_clk = ~ref_clk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(logic w, logic r, logic [2:0] i, logic [1:0] o,
                    cfgatr_pkg::cfgatr_size_t s, logic [31:0] d);
    @(posedge ref_clk) #1 req = '{w, r, i, o, s, d};
    @(posedge ref_clk) #1 req = '0;
  endtask
  task automatic t_reset();
    chk(regOut[63:32], 32'h00FF_5A00);
    op(0, 0, 0, 0, BY, 0);
    strapIn = '0;
    op(0, 0, 0, 0, BY, 0);
    chk(regOut[103:96], 8'hC3);
    $display("t_reset done");
  endtask
  task automatic t_attr();
    op(1, 0, 1, 0, DW, 32'hFFFF_FFFF);
    chk(regOut[63:32], 32'hFF00_5AFF);
    op(1, 0, 1, 0, DW, 0);
    chk(regOut[63:32], 32'hFF00_5A00);
    op(0, 1, 1, 1, BY, 0);
    chk({rdValid, rdData[7:0]}, 9'h15A);
    op(0, 1, 1, 0, DW, 0);
    op(1, 0, 1, 0, DW, rdData | 32'h0000_0011);
    chk(regOut[63:32], 32'hFF00_5A11);
    $display("t_attr done");
  endtask
  task automatic t_setwin();
    @(posedge ref_clk) #1 setIn[48] = 1;
    req = '{1, 0, 3'h1, 2'h2, BY, 32'h1};
    @(posedge ref_clk) #1 setIn = '0;
    req = '0;
    chk(regOut[55:48], 8'h01);
    op(1, 0, 1, 2, BY, 1);
    chk(regOut[55:48], 8'h00);
    $display("t_setwin done");
  endtask
  task automatic t_lock();
    op(1, 0, 2, 0, DW, 32'h1234_5600);
    op(1, 0, 2, 0, BY, 1);
    op(1, 0, 2, 2, WD, 32'hFFFF);
    chk(regOut[95:64], 32'h1234_5601);
    $display("t_lock done");
  endtask
  task automatic t_addr();
    op(1, 0, 0, 0, BY, 8'hAB);
    chk(regOut[31:0], 0);
    op(1, 0, 0, 0, DW, 32'h8000_0010);
    chk(regOut[31:0], 32'h8000_0010);
    op(0, 1, 7, 0, DW, 0);
    chk(rdValid, 1);
    chk(rdData, 0);
    $display("t_addr done");
  endtask
  task automatic t_rereset();
    rstn = 0;
    @(posedge ref_clk) #1 rstn = 1;
    op(1, 0, 1, 0, DW, 32'h7700_0000);
    chk(regOut[103:96], 8'h00);
    chk(regOut[63:32], 32'h77FF_5A00);
    op(1, 0, 2, 2, WD, 32'hBEEF);
    chk(regOut[95:64], 32'hBEEF_0000);
    $display("t_rereset done");
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1;
    t_reset();
    t_attr();
    t_setwin();
    t_lock();
    t_addr();
    t_rereset();
    end_of_test();
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule
bind cfgatr_bank cfgatr_bank_sva #(.NUM_REGS(NUM_REGS)) u_sva (.ref_clk,
  .rstn, .req, .strapIn, .setIn, .rdData, .rdValid, .regOut);
`default_nettype wire
